// File: chk_pkg.sv
// Constants, field layout and remainder arithmetic for the checksum calculator.
// Assumes a single 25 MHz clock domain with a synchronous active-high reset.
package chk_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [3:0] REG_CONTROL_OFS = 4'h0;
  localparam logic [3:0] REG_DATA_IN_OFS = 4'h4;
  localparam logic [3:0] REG_RESULT_OFS = 4'h8;

  // Control register layout.
  localparam int POLY_SEL_LSB = 0;
  localparam int BIT_ORDER_BIT = 6;
  localparam logic [7:0] CONTROL_WMASK = 8'h47;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_IN_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_RESET = 32'h0000_0000;
  localparam logic WAIT_RESET = 1'b1;

  // Polynomial selection codes.
  localparam logic [2:0] POLY_OFF = 3'h0;
  localparam logic [2:0] POLY_8 = 3'h1;
  localparam logic [2:0] POLY_16A = 3'h2;
  localparam logic [2:0] POLY_16B = 3'h3;
  localparam logic [2:0] POLY_32A = 3'h4;
  localparam logic [2:0] POLY_32B = 3'h5;

  // Generator polynomials in normal form, top term implied.
  localparam logic [31:0] POLY_8_VALUE = 32'h0000_0007;
  localparam logic [31:0] POLY_16A_VALUE = 32'h0000_8005;
  localparam logic [31:0] POLY_16B_VALUE = 32'h0000_1021;
  localparam logic [31:0] POLY_32A_VALUE = 32'h04c1_1db7;
  localparam logic [31:0] POLY_32B_VALUE = 32'h1edc_6f41;

  localparam logic [5:0] WIDTH_8 = 6'd8;
  localparam logic [5:0] WIDTH_16 = 6'd16;
  localparam logic [5:0] WIDTH_32 = 6'd32;

  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALC = 2'b10
  } engine_state_e;

  function automatic logic [5:0] poly_width(input logic [2:0] sel);
    if (sel == POLY_8) begin
      return WIDTH_8;
    end else if (sel == POLY_16A || sel == POLY_16B) begin
      return WIDTH_16;
    end
    return WIDTH_32;
  endfunction : poly_width

  function automatic logic [31:0] poly_value(input logic [2:0] sel);
    case (sel)
      POLY_8: return POLY_8_VALUE;
      POLY_16A: return POLY_16A_VALUE;
      POLY_16B: return POLY_16B_VALUE;
      POLY_32A: return POLY_32A_VALUE;
      POLY_32B: return POLY_32B_VALUE;
      default: return 32'h0000_0000;
    endcase
  endfunction : poly_value

  function automatic logic [31:0] width_mask(input logic [5:0] w);
    if (w == WIDTH_32) begin
      return 32'hffff_ffff;
    end
    return (32'h0000_0001 << w) - 32'h0000_0001;
  endfunction : width_mask

  function automatic logic [31:0] reflect(input logic [31:0] v, input logic [5:0] w);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (i < int'(w)) begin
        r[int'(w) - 1 - i] = v[i];
      end
    end
    return r;
  endfunction : reflect

  // One full parallel update: 8 data bits per step, or 32 in the 32-bit modes.
  function automatic logic [31:0] rem_next(input logic [31:0] rem, input logic [31:0] data,
                                           input logic [2:0] sel, input logic msb_first);
    logic [31:0] c;
    logic [31:0] p;
    logic [5:0] w;
    int n;
    logic fb;
    w = poly_width(sel);
    // Seeds are stored unmasked, so bits above the width must not shift into a right shift.
    c = rem & width_mask(w);
    n = (w == WIDTH_32) ? 32 : 8;
    p = msb_first ? poly_value(sel) : reflect(poly_value(sel), w);
    for (int i = 0; i < 32; i++) begin
      if (i < n) begin
        if (msb_first) begin
          fb = c[int'(w) - 1] ^ data[n - 1 - i];
          c = (c << 1) & width_mask(w);
        end else begin
          fb = c[0] ^ data[i];
          c = c >> 1;
        end
        if (fb) begin
          c = c ^ p;
        end
      end
    end
    return c;
  endfunction : rem_next

endpackage : chk_pkg

// File: word_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-high reset and a power-of-two depth.
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != FULL_COUNT);
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers wrap by overflow, which is why the depth must be a power of two.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
      end
      if (pop) begin
        rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= (AW + 1)'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_q <= (AW + 1)'(count_q - 1'b1);
    end
  end

endmodule : word_fifo

// File: checksum_calc.sv
// Software-driven checksum generator behind an Avalon-MM slave with waitrequest.
// Assumes a 25 MHz clock, synchronous active-high reset and a master that holds
// each request until it samples waitrequest low.

// Functional notes
// - Codes 001-011 pick 8/16-bit polynomials.
// - Codes 100 and 101 pick 32-bit polynomials.
// - Codes 000, 110, 111 compute nothing.
// - Control bit 6 chooses LSB or MSB first.
// - Byte modes update eight bits per step.
// - Word modes update thirty-two bits per step.
// - Data input is one byte in 8/16-bit modes, a full word in 32-bit modes.
// - Result read size follows selected width.
module checksum_calc (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o
);
  import chk_pkg::*;

  logic [7:0] crc_control_q;
  logic [31:0] crc_result_output_q;
  logic [31:0] crc_data_input_q;
  logic [31:0] readdata_q;
  logic wait_q;
  logic [31:0] work_q;
  engine_state_e state_q;

  logic [2:0] poly_sel;
  logic bit_order_select;
  logic [5:0] cur_width;
  logic word_mode;
  logic mode_off;
  logic sel_ctrl;
  logic sel_data;
  logic sel_result;
  logic req;
  logic accept;
  logic drained;
  logic ready_now;
  logic size_ok;
  logic [31:0] lane_data;
  logic [31:0] read_value;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [31:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;

  function automatic logic lane_onehot(input logic [3:0] be);
    return (be == 4'h1) || (be == 4'h2) || (be == 4'h4) || (be == 4'h8);
  endfunction : lane_onehot

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  assign poly_sel = crc_control_q[POLY_SEL_LSB +: 3];
  assign bit_order_select = crc_control_q[BIT_ORDER_BIT];
  assign cur_width = poly_width(poly_sel);
  assign word_mode = (cur_width == WIDTH_32);
  assign mode_off = !(poly_sel inside {POLY_8, POLY_16A, POLY_16B, POLY_32A, POLY_32B});

  assign req = read_i || write_i;
  assign accept = req && !wait_q;
  assign drained = !fifo_out_valid && (state_q == ST_IDLE);

  always_comb begin
    sel_ctrl = 1'b0;
    sel_data = 1'b0;
    sel_result = 1'b0;
    if (address_i == REG_CONTROL_OFS) begin
      sel_ctrl = 1'b1;
    end else if (address_i == REG_DATA_IN_OFS) begin
      sel_data = 1'b1;
    end else if (address_i == REG_RESULT_OFS) begin
      sel_result = 1'b1;
    end
  end

  // Control and result accesses wait for the pipeline to drain, so a result read
  // always reflects every word written before it and a mode change never splits
  // a queued word between two polynomials.
  always_comb begin
    ready_now = 1'b1;
    if (sel_data && write_i) begin
      ready_now = fifo_in_ready;
    end else if (sel_ctrl || sel_result) begin
      ready_now = drained;
    end
  end

  // Byte modes take the single enabled lane; word modes need all four lanes.
  always_comb begin
    lane_data = 32'h0000_0000;
    size_ok = 1'b0;
    if (word_mode) begin
      size_ok = (byteenable_i == 4'hf);
      lane_data = writedata_i;
    end else begin
      size_ok = lane_onehot(byteenable_i);
      for (int i = 0; i < 4; i++) begin
        if (byteenable_i[i]) begin
          lane_data = {24'h00_0000, writedata_i[8*i +: 8]};
        end
      end
    end
  end

  assign fifo_in_valid = accept && write_i && sel_data && size_ok && !mode_off;
  assign fifo_in_data = lane_data;
  assign fifo_out_ready = (state_q == ST_IDLE);

  word_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // Bus handshake: waitrequest drops for exactly one cycle per request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= WAIT_RESET;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (req && ready_now) begin
      wait_q <= 1'b0;
    end
  end

  always_comb begin
    read_value = 32'h0000_0000;
    if (sel_ctrl) begin
      read_value = {24'h00_0000, crc_control_q};
    end else if (sel_data) begin
      read_value = crc_data_input_q;
    end else if (sel_result) begin
      read_value = crc_result_output_q & width_mask(cur_width);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      readdata_q <= READ_RESET;
    end else if (read_i && wait_q && ready_now) begin
      readdata_q <= read_value;
    end
  end

  // Reserved control bits are never stored, so they read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_control_q <= CONTROL_RESET;
    end else if (accept && write_i && sel_ctrl && byteenable_i[0]) begin
      crc_control_q <= writedata_i[7:0] & CONTROL_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_data_input_q <= DATA_IN_RESET;
    end else if (fifo_in_valid) begin
      crc_data_input_q <= fifo_in_data;
    end
  end

  // Engine: take one queued word, then fold it into the remainder.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      work_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (fifo_out_valid) begin
            work_q <= fifo_out_data;
            state_q <= ST_CALC;
          end
        end
        ST_CALC: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // A seed write only happens when drained, so it never meets an engine update.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_result_output_q <= RESULT_RESET;
    end else if (accept && write_i && sel_result) begin
      crc_result_output_q <= be_merge(crc_result_output_q, writedata_i, byteenable_i);
    end else if (state_q == ST_CALC) begin
      crc_result_output_q <= rem_next(crc_result_output_q, work_q, poly_sel, bit_order_select);
    end
  end

  assign readdata_o = readdata_q;
  assign waitrequest_o = wait_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_pop;
    fifo_out_valid && (state_q == ST_IDLE);
  endsequence

  sequence seq_calc;
    state_q == ST_CALC;
  endsequence

  AST_ACK_PULSE:
    assert property (!wait_q |=> wait_q)
    else $error("waitrequest low for more than one cycle");

  AST_POP_ONE_STEP:
    assert property (((!word_mode) and seq_pop) |=> seq_calc ##1 (state_q == ST_IDLE))
    else $error("byte step did not take exactly one operation");

  AST_WORD_CAPTURE:
    assert property ((word_mode and seq_pop) |=> (seq_calc and (work_q == $past(fifo_out_data))))
    else $error("word not captured whole for one step");

  AST_RESULT_UPDATE:
    assert property (seq_calc |=> crc_result_output_q ==
                     rem_next($past(crc_result_output_q), $past(work_q), poly_sel,
                              bit_order_select))
    else $error("result not updated from previous value and data");

  AST_BYTE_WIDTH:
    assert property ((seq_calc and (poly_sel == POLY_8 && crc_result_output_q[31:8] == 24'h0))
                     |=> crc_result_output_q[31:8] == 24'h00_0000)
    else $error("8-bit remainder spilled above bit 7");

  AST_POLY32_MSB:
    assert property ((seq_calc and (poly_sel == POLY_32A && bit_order_select &&
                      work_q == 32'h0 && crc_result_output_q == 32'h0000_0001))
                     |=> crc_result_output_q == POLY_32A_VALUE)
    else $error("32-bit MSB-first step uses wrong polynomial");

  AST_POLY32_LSB:
    assert property ((seq_calc and (poly_sel == POLY_32B && !bit_order_select &&
                      work_q == 32'h0 && crc_result_output_q == 32'h8000_0000))
                     |=> crc_result_output_q == reflect(POLY_32B_VALUE, WIDTH_32))
    else $error("32-bit LSB-first step not reflected");

  AST_OFF_NO_PUSH:
    assert property (mode_off |-> (!fifo_in_valid && !fifo_out_valid && state_q == ST_IDLE))
    else $error("data queued while no polynomial selected");

  AST_SIZE_GATE:
    assert property ((accept && write_i && sel_data && !size_ok) |-> !fifo_in_valid)
    else $error("wrong-size data write was queued");

  AST_READ_MASK:
    assert property ((read_i && wait_q && ready_now && sel_result && cur_width == WIDTH_16)
                     |=> readdata_q[31:16] == 16'h0000)
    else $error("16-bit result read shows upper half");

  AST_SEED_LOAD:
    assert property ((accept && write_i && sel_result && byteenable_i == 4'hf)
                     |=> crc_result_output_q == $past(writedata_i))
    else $error("seed write not loaded");

endmodule : checksum_calc

// File: tb_checksum_calc.sv
// Self-checking bench for the checksum calculator behind its Avalon-MM slave.
// Assumes the design's package and modules are compiled first; one clock, no partner model.
module tb_checksum_calc import chk_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i;
  logic rst_i;
  logic [3:0] address_i;
  logic read_i;
  logic write_i;
  logic [3:0] byteenable_i;
  logic [31:0] writedata_i;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  int num_errors;
  int n_tests;
  logic [31:0] v;
  logic [31:0] rem;
  logic [31:0] msk;
  logic [31:0] d;
  logic [2:0] s;
  logic m;
  int lane;

  checksum_calc dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .address_i(address_i),
    .read_i(read_i),
    .write_i(write_i),
    .byteenable_i(byteenable_i),
    .writedata_i(writedata_i),
    .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o)
  );

  always #20 clk_i = ~clk_i;

  task give_verdict();
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  endtask : check

  // Returns in the time step of the edge that sees waitrequest low, before the design updates.
  task wait_answer();
    int k;
    k = 0;
    @(posedge clk_i);
    while (waitrequest_o !== 1'b0 && k < 500) begin
      @(posedge clk_i);
      k++;
    end
    if (waitrequest_o !== 1'b0) begin
      $display("unexpected waitrequest: expected 0 seen %b", waitrequest_o);
      num_errors++;
      give_verdict();
    end
  endtask : wait_answer

  task bus_write(input logic [3:0] a, input logic [3:0] be, input logic [31:0] wd);
    @(posedge clk_i);
    address_i <= a;
    byteenable_i <= be;
    writedata_i <= wd;
    write_i <= 1'b1;
    wait_answer();
    write_i <= 1'b0;
  endtask : bus_write

  task bus_read(input logic [3:0] a, output logic [31:0] rd);
    @(posedge clk_i);
    address_i <= a;
    byteenable_i <= 4'hf;
    read_i <= 1'b1;
    wait_answer();
    rd = readdata_o;
    read_i <= 1'b0;
  endtask : bus_read

  function automatic int tb_width(input logic [2:0] sel);
    return (sel == POLY_8) ? 8 : (sel < POLY_32A) ? 16 : 32;
  endfunction : tb_width

  function automatic logic [31:0] tb_mask(input int w);
    return (w == 32) ? 32'hffff_ffff : (32'h0000_0001 << w) - 32'h0000_0001;
  endfunction : tb_mask

  // Bit-serial reference: one bit per loop pass, independent of the design's arithmetic.
  function automatic logic [31:0] tb_step(input logic [31:0] r, input logic [31:0] dd,
                                          input logic [2:0] sel, input logic msb);
    int w;
    int n;
    logic [31:0] p;
    logic [31:0] rp;
    logic fb;
    w = tb_width(sel);
    n = (w == 32) ? 32 : 8;
    p = (sel == POLY_8) ? POLY_8_VALUE : (sel == POLY_16A) ? POLY_16A_VALUE :
        (sel == POLY_16B) ? POLY_16B_VALUE : (sel == POLY_32A) ? POLY_32A_VALUE : POLY_32B_VALUE;
    rp = 32'h0000_0000;
    for (int i = 0; i < w; i++) begin
      rp[w - 1 - i] = p[i];
    end
    for (int i = 0; i < n; i++) begin
      if (msb) begin
        fb = r[w - 1] ^ dd[n - 1 - i];
        r = (r << 1) & tb_mask(w);
        if (fb) r = r ^ p;
      end else begin
        fb = r[0] ^ dd[i];
        r = r >> 1;
        if (fb) r = r ^ rp;
      end
    end
    return r;
  endfunction : tb_step

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    address_i = 4'h0;
    read_i = 1'b0;
    write_i = 1'b0;
    byteenable_i = 4'h0;
    writedata_i = 32'h0000_0000;
    num_errors = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus_read(REG_CONTROL_OFS, v);
    check("control reset", v, {24'h000000, CONTROL_RESET});
    bus_read(REG_RESULT_OFS, v);
    check("result reset", v, RESULT_RESET);
    // Every polynomial in both bit orders, with a seed and three inputs on varying lanes.
    for (int si = 1; si <= 5; si++) begin
      for (int mi = 0; mi < 2; mi++) begin
        s = si[2:0];
        m = mi[0];
        bus_write(REG_CONTROL_OFS, 4'h1, {24'h000000, 1'b0, m, 3'b000, s});
        msk = tb_mask(tb_width(s));
        rem = 32'hc3a5_0f96 & msk;
        bus_write(REG_RESULT_OFS, 4'hf, rem);
        for (int k = 0; k < 3; k++) begin
          d = 32'h8d2e_61f7 ^ {8{si[1:0], k[1:0]}};
          if (tb_width(s) == 32) begin
            bus_write(REG_DATA_IN_OFS, 4'hf, d);
          end else begin
            lane = (k + si) % 4;
            bus_write(REG_DATA_IN_OFS, 4'h1 << lane, d);
            d = {24'h000000, d[lane * 8 +: 8]};
          end
          rem = tb_step(rem, d, s, m);
        end
        bus_read(REG_RESULT_OFS, v);
        check("result", v, rem & msk);
      end
    end
    // Wrong access size is ignored in both word and byte modes.
    bus_write(REG_CONTROL_OFS, 4'h1, {24'h000000, 5'h08, POLY_32A});
    bus_write(REG_RESULT_OFS, 4'hf, 32'h1111_2222);
    bus_write(REG_DATA_IN_OFS, 4'h1, 32'h0000_00a5);
    bus_read(REG_RESULT_OFS, v);
    check("result after byte write", v, 32'h1111_2222);
    bus_write(REG_RESULT_OFS, 4'hf, 32'h0000_0001);
    bus_write(REG_DATA_IN_OFS, 4'hf, 32'h0000_0000);
    bus_read(REG_RESULT_OFS, v);
    check("result x32 msb", v, POLY_32A_VALUE);
    bus_write(REG_CONTROL_OFS, 4'h1, {24'h000000, 5'h00, POLY_8});
    bus_write(REG_RESULT_OFS, 4'hf, 32'h0000_005a);
    bus_write(REG_DATA_IN_OFS, 4'hf, 32'h3c3c_3c3c);
    bus_read(REG_RESULT_OFS, v);
    check("result after word write", v, 32'h0000_005a);
    bus_write(REG_RESULT_OFS, 4'hf, 32'hffff_ff5a);
    bus_write(REG_DATA_IN_OFS, 4'h2, 32'h0000_c300);
    bus_read(REG_RESULT_OFS, v);
    check("result unmasked seed", v, tb_step(32'h0000_005a, 32'h0000_00c3, POLY_8, 1'b0));
    // Codes without a polynomial leave the result alone; reserved control bits read zero.
    for (int ci = 0; ci < 3; ci++) begin
      s = (ci == 0) ? 3'h0 : (ci == 1) ? 3'h6 : 3'h7;
      bus_write(REG_CONTROL_OFS, 4'h1, {24'h000000, 5'h1f, s});
      bus_read(REG_CONTROL_OFS, v);
      check("control", v, {24'h000000, 5'h08, s});
      bus_write(REG_RESULT_OFS, 4'hf, 32'h9abc_def0);
      bus_write(REG_DATA_IN_OFS, 4'hf, 32'h0f1e_2d3c);
      bus_write(REG_DATA_IN_OFS, 4'h1, 32'h0000_0077);
      bus_read(REG_RESULT_OFS, v);
      check("result idle code", v, 32'h9abc_def0);
    end
    // Unmapped place reads zero and swallows writes.
    bus_write(4'hc, 4'hf, 32'hffff_ffff);
    bus_read(4'hc, v);
    check("unmapped", v, 32'h0000_0000);
    bus_read(REG_CONTROL_OFS, v);
    check("control after unmapped", v, {24'h000000, 8'h47});
    // Back-to-back words deeper than the queue; the result read waits for the drain.
    bus_write(REG_CONTROL_OFS, 4'h1, {24'h000000, 5'h00, POLY_32B});
    bus_write(REG_RESULT_OFS, 4'hf, 32'h8000_0000);
    bus_write(REG_DATA_IN_OFS, 4'hf, 32'h0000_0000);
    bus_read(REG_RESULT_OFS, v);
    check("result x32 lsb", v, tb_step(32'h8000_0000, 32'h0, POLY_32B, 1'b0));
    rem = 32'hffff_ffff;
    bus_write(REG_RESULT_OFS, 4'hf, rem);
    for (int k = 0; k < 18; k++) begin
      d = {4{k[3:0], 4'ha}} ^ 32'h0102_0408;
      bus_write(REG_DATA_IN_OFS, 4'hf, d);
      rem = tb_step(rem, d, POLY_32B, 1'b0);
    end
    bus_read(REG_RESULT_OFS, v);
    check("result stream", v, rem);
    give_verdict();
  end
endmodule : tb_checksum_calc
